// [mla_pkg.sv]
`default_nettype none
package mla_pkg;
	// =========================================================
	// timing
	localparam int CLK_HZ       = 10_000_000;
	localparam int CYC_PER_MS   = CLK_HZ / 1000;
	localparam int KEY_HOLD_MS  = 5000;
	// the key pair must be held longer than the hold time
	localparam int KEY_HOLD_CYC = KEY_HOLD_MS * CYC_PER_MS + 1;
	localparam int BLINK_MS     = 500;
	localparam int BLINK_CYC    = BLINK_MS * CYC_PER_MS;
	// =========================================================
	// sizes and codes
	localparam int N_COND     = 32;
	localparam int HIST_DEPTH = 4;
	localparam int TERM_N     = 6;
	localparam int CODE_W     = 8;
	localparam logic [7:0] TERM_FUNC_MINOR = 8'h62;
	// =========================================================
	// register byte addresses
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_STATUS   = 8'h00;
	localparam logic [7:0] ADR_CLASS0   = 8'h04;
	localparam logic [7:0] ADR_CLASS1   = 8'h08;
	localparam logic [7:0] ADR_TERM0    = 8'h0c;
	localparam logic [7:0] ADR_TERM1    = 8'h10;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADR_HIST0    = 8'h20;
	localparam logic [7:0] ADR_HIST_END = 8'h2c;
	// =========================================================
	// fields
	localparam int ST_MINOR  = 0;
	localparam int ST_TEST   = 1;
	localparam int ST_EFAULT = 2;
	localparam int ST_DISP   = 3;
	localparam int ST_IND    = 4;
	localparam int ST_LAMP   = 5;
	localparam int IRQ_W         = 4;
	localparam int IRQ_MINOR_ON  = 0;
	localparam int IRQ_MINOR_OFF = 1;
	localparam int IRQ_TEST      = 2;
	localparam int IRQ_EFAULT    = 3;
	// =========================================================
	// reset values
	localparam logic [31:0]      CLASS_RST = 32'h0000_0000;
	localparam logic [31:0]      TERM_RST  = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] MASK_RST  = 4'h0;
endpackage : mla_pkg
`default_nettype wire

// [mla_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// counts enabled cycles; pulses done after CYC of them
module mla_timer #(
	parameter int CYC      = 2,
	parameter bit PERIODIC = 1'b0
) (
	input  wire logic clk_i, // system clock
	input  wire logic rst_i, // async reset, high
	input  wire logic en_i,  // count while high, restart when low
	output var  logic done_o // one-cycle pulse
);
	localparam int W = $clog2(CYC + 1);
	localparam logic [W-1:0] LAST = W'(CYC - 1);

	if (CYC < 1) begin : g_bad_cyc
		$error("mla_timer: CYC must be at least 1");
	end

	logic [W-1:0] cnt;
	logic         spent;
	wire          hit = en_i && !spent && (cnt == LAST);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt    <= '0;
			spent  <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= hit;
			if (!en_i || hit) begin
				cnt <= '0;
			end else if (!spent) begin
				cnt <= cnt + W'(1);
			end
			// one-shot mode waits for en to drop before it can fire again
			spent <= en_i && (spent || (hit && !PERIODIC));
		end
	end
endmodule : mla_timer
`default_nettype wire

// [mla_hist.sv]
`timescale 1ns/1ps
`default_nettype none
// age-ordered factor history, entry 0 is the latest
module mla_hist #(
	parameter int DEPTH = 4,
	parameter int W     = 8
) (
	input  wire logic                     clk_i,     // system clock
	input  wire logic                     rst_i,     // async reset, high
	input  wire logic                     push_i,    // record a new factor
	input  wire logic [W-1:0]             code_i,    // factor code to record
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i, // entry age to read
	output var  logic [W-1:0]             rd_data_o, // registered read data
	output var  logic [W-1:0]             latest_o   // entry 0
);
	if (DEPTH < 2) begin : g_bad_depth
		$error("mla_hist: DEPTH must be at least 2");
	end

	logic [W-1:0] mem [DEPTH];

	// =========================================================
	// shift on push
	// older factors age
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				mem[i] <= '0;
			end else if (push_i) begin
				mem[i] <= (i == 0) ? code_i : mem[(i == 0) ? 0 : i - 1];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem[rd_addr_i];
		end
	end

	assign latest_o = mem[0];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	hist_age_a : assert property (push_i |=> mem[1] == $past(mem[0]))
		else $error("history entry did not age");
endmodule : mla_hist
`default_nettype wire

// [mla_annunciator.sv]
// Summary of operation
// - raise test alarm after key pair held continuously longer than five seconds.
// - escape key press during test alarm clears it.
// - enable-circuit fault latches; alarm reset input cannot clear it, only power.
// - minor alarm keeps running, no trip, shows minor-alarm indication.
// - during minor alarm blink keypad-control lamp and assert minor-alarm signal.
// - terminal carries minor-alarm signal only when its function code is 98.
// - class0 setting chooses per condition minor or heavy alarm; class1 is not used.
// - latest minor-alarm factor is recorded as a readable alarm code.
// - previous three factors are kept in age order, each readable.
// - operator may return to normal display; lamp keeps blinking.
// - factor removed clears indication and lamp; blinking while any factor remains.
// - minor-alarm output drops by itself once all factors are gone.
`timescale 1ns/1ps
`default_nettype none
module mla_annunciator #(
	parameter int KEY_HOLD_CYC = mla_pkg::KEY_HOLD_CYC,
	parameter int BLINK_CYC    = mla_pkg::BLINK_CYC,
	parameter int N_COND       = mla_pkg::N_COND
) (
	input  wire logic                        SYS_CLK_I,      // 10 MHz clock
	input  wire logic                        SYS_RST_I,      // async reset, high
	input  wire logic                        CYC_I,          // wishbone cycle
	input  wire logic                        STB_I,          // wishbone strobe
	input  wire logic                        WE_I,           // wishbone write
	input  wire logic [mla_pkg::ADR_W-1:0]   ADR_I,          // byte address
	input  wire logic [3:0]                  SEL_I,          // byte selects
	input  wire logic [31:0]                 DAT_I,          // write data
	output var  logic [31:0]                 DAT_O,          // read data
	output var  logic                        ACK_O,          // wishbone ack
	input  wire logic [N_COND-1:0]           COND_I,         // detected abnormal conditions
	input  wire logic                        KEY_A_I,        // first key of test pair
	input  wire logic                        KEY_B_I,        // second key of test pair
	input  wire logic                        KEY_ESC_I,      // escape key
	input  wire logic                        KEY_DISP_I,     // return-to-normal-display key
	input  wire logic                        ALARM_RESET_I,  // alarm reset command
	input  wire logic                        ENABLE_FAULT_I, // enable-circuit fault detected
	output var  logic                        TEST_ALARM_O,   // test alarm state
	output var  logic                        ENABLE_FAULT_O, // latched enable-circuit fault
	output var  logic                        MINOR_IND_O,    // minor_alarm_indication shown
	output var  logic                        LAMP_O,         // keypad-control lamp
	output var  logic                        MINOR_ALARM_O,  // minor_alarm_output signal
	output var  logic [mla_pkg::TERM_N-1:0]  TERM_O,         // digital output terminals
	output var  logic                        IRQ_O           // level interrupt
);
	localparam int HA_W = $clog2(mla_pkg::HIST_DEPTH);

	if (N_COND < 1 || N_COND > 32) begin : g_bad_cond
		$error("mla_annunciator: N_COND must be 1..32");
	end
	if (N_COND >= (1 << mla_pkg::CODE_W) - 1) begin : g_bad_code
		$error("mla_annunciator: codes too narrow");
	end

	// =========================================================
	// functions
	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
	                                          input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction : merge_sel

	// code of the lowest set condition, plus one so zero means none
	function automatic logic [mla_pkg::CODE_W-1:0] first_code(input logic [N_COND-1:0] v);
		logic [mla_pkg::CODE_W-1:0] c;
		c = '0;
		for (int k = N_COND - 1; k >= 0; k--) begin
			if (v[k]) c = mla_pkg::CODE_W'(k + 1);
		end
		return c;
	endfunction : first_code

	// =========================================================
	// registers
	logic [31:0]               class0;
	logic [31:0]               class1;
	logic [31:0]               term0;
	logic [31:0]               term1;
	logic [mla_pkg::IRQ_W-1:0] irq_stat;
	logic [mla_pkg::IRQ_W-1:0] irq_mask;
	logic                      pend;
	logic                      disp_normal;
	logic [N_COND-1:0]         cond_prev;

	// =========================================================
	// bus decode
	wire                      req       = CYC_I && STB_I && !pend && !ACK_O;
	// a write lands at the edge where the master samples ack
	wire                      wr        = CYC_I && STB_I && WE_I && ACK_O;
	wire                      wr_class0 = wr && (ADR_I == mla_pkg::ADR_CLASS0);
	wire                      wr_class1 = wr && (ADR_I == mla_pkg::ADR_CLASS1);
	wire                      wr_term0  = wr && (ADR_I == mla_pkg::ADR_TERM0);
	wire                      wr_term1  = wr && (ADR_I == mla_pkg::ADR_TERM1);
	wire                      wr_istat  = wr && (ADR_I == mla_pkg::ADR_IRQ_STAT);
	wire                      wr_imask  = wr && (ADR_I == mla_pkg::ADR_IRQ_MASK);
	wire                      hist_hit  = (ADR_I >= mla_pkg::ADR_HIST0) && (ADR_I <= mla_pkg::ADR_HIST_END)
	                                      && (ADR_I[1:0] == 2'b00);
	wire [HA_W-1:0]           hist_addr = ADR_I[2 +: HA_W];
	wire [31:0]               w1c       = merge_sel(32'h0000_0000, DAT_I, SEL_I);
	wire [31:0]               mask_wr   = merge_sel(32'(irq_mask), DAT_I, SEL_I);

	// =========================================================
	// minor alarm detection
	// class0 setting picks minor conditions
	wire [63:0]               class_all  = {class1, class0};
	wire [N_COND-1:0]         class_mask = class_all[N_COND-1:0];
	wire [N_COND-1:0]         minor_cond = COND_I & class_mask;
	wire                      next_minor = |minor_cond;
	wire [N_COND-1:0]         rise       = minor_cond & ~cond_prev;
	wire                      push       = |rise;
	wire [mla_pkg::CODE_W-1:0] push_code = first_code(rise);
	// normal display on request, lasts while alarm persists
	wire                      next_disp  = next_minor && (disp_normal || (KEY_DISP_I && MINOR_ALARM_O));

	wire [63:0]               term_all = {term1, term0};
	wire [mla_pkg::TERM_N-1:0] term_is_minor;
	for (genvar t = 0; t < mla_pkg::TERM_N; t++) begin : g_term
		assign term_is_minor[t] = (term_all[t*8 +: 8] == mla_pkg::TERM_FUNC_MINOR);
	end

	// =========================================================
	// timers and history
	logic                      hold_done;
	logic                      blink_tick;
	logic [mla_pkg::CODE_W-1:0] hist_rd;
	logic [mla_pkg::CODE_W-1:0] hist_latest;

	mla_timer #(.CYC(KEY_HOLD_CYC), .PERIODIC(1'b0)) u_hold (
		.clk_i  (SYS_CLK_I),
		.rst_i  (SYS_RST_I),
		.en_i   (KEY_A_I && KEY_B_I),
		.done_o (hold_done)
	);

	mla_timer #(.CYC(BLINK_CYC), .PERIODIC(1'b1)) u_blink (
		.clk_i  (SYS_CLK_I),
		.rst_i  (SYS_RST_I),
		.en_i   (MINOR_ALARM_O),
		.done_o (blink_tick)
	);

	// latest factor recorded on each cycle with a new minor condition, the lowest if several
	mla_hist #(.DEPTH(mla_pkg::HIST_DEPTH), .W(mla_pkg::CODE_W)) u_hist (
		.clk_i     (SYS_CLK_I),
		.rst_i     (SYS_RST_I),
		.push_i    (push),
		.code_i    (push_code),
		.rd_addr_i (hist_addr),
		.rd_data_o (hist_rd),
		.latest_o  (hist_latest)
	);

	// =========================================================
	// read mux
	wire [31:0] status = 32'({LAMP_O, MINOR_IND_O, disp_normal, ENABLE_FAULT_O, TEST_ALARM_O, MINOR_ALARM_O});
	wire [31:0] rd_mux =
		(ADR_I == mla_pkg::ADR_STATUS)   ? status :
		(ADR_I == mla_pkg::ADR_CLASS0)   ? class0 :
		(ADR_I == mla_pkg::ADR_CLASS1)   ? class1 :
		(ADR_I == mla_pkg::ADR_TERM0)    ? term0 :
		(ADR_I == mla_pkg::ADR_TERM1)    ? term1 :
		(ADR_I == mla_pkg::ADR_IRQ_STAT) ? 32'(irq_stat) :
		(ADR_I == mla_pkg::ADR_IRQ_MASK) ? 32'(irq_mask) :
		hist_hit                         ? 32'(hist_rd) : 32'h0000_0000;

	// events: set beats a same-cycle clear
	wire [mla_pkg::IRQ_W-1:0] ev = {
		ENABLE_FAULT_I && !ENABLE_FAULT_O,
		hold_done && !TEST_ALARM_O,
		!next_minor && MINOR_ALARM_O,
		next_minor && !MINOR_ALARM_O};
	wire [mla_pkg::IRQ_W-1:0] next_irq_stat = (irq_stat & ~(wr_istat ? w1c[mla_pkg::IRQ_W-1:0] : '0)) | ev;

	// =========================================================
	// bus slave
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pend  <= 1'b0;
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else begin
			pend  <= req;
			ACK_O <= pend;
			DAT_O <= (pend && !WE_I) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			class0   <= mla_pkg::CLASS_RST;
			class1   <= mla_pkg::CLASS_RST;
			term0    <= mla_pkg::TERM_RST;
			term1    <= mla_pkg::TERM_RST;
			irq_mask <= mla_pkg::MASK_RST;
		end else begin
			if (wr_class0) class0 <= merge_sel(class0, DAT_I, SEL_I);
			if (wr_class1) class1 <= merge_sel(class1, DAT_I, SEL_I);
			if (wr_term0) term0 <= merge_sel(term0, DAT_I, SEL_I);
			if (wr_term1) term1 <= merge_sel(term1, DAT_I, SEL_I);
			if (wr_imask) irq_mask <= mask_wr[mla_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			irq_stat <= '0;
			IRQ_O    <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			IRQ_O    <= |(next_irq_stat & irq_mask);
		end
	end

	// =========================================================
	// alarm state
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			TEST_ALARM_O   <= 1'b0;
			ENABLE_FAULT_O <= 1'b0;
		end else begin
			// escape clears, a new hold wins
			TEST_ALARM_O   <= hold_done || (TEST_ALARM_O && !KEY_ESC_I);
			ENABLE_FAULT_O <= ENABLE_FAULT_O || ENABLE_FAULT_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cond_prev     <= '0;
			disp_normal   <= 1'b0;
			MINOR_ALARM_O <= 1'b0;
			MINOR_IND_O   <= 1'b0;
			LAMP_O        <= 1'b0;
			TERM_O        <= '0;
		end else begin
			cond_prev     <= minor_cond;
			disp_normal   <= next_disp;
			// follows the factors, no reset needed
			MINOR_ALARM_O <= next_minor;
			// indication while minor and not dismissed
			MINOR_IND_O   <= next_minor && !next_disp;
			LAMP_O        <= next_minor && (blink_tick ? !LAMP_O : LAMP_O);
			TERM_O        <= {mla_pkg::TERM_N{next_minor}} & term_is_minor;
		end
	end

	// =========================================================
	// assertions
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_clear;
		!next_minor ##1 1'b1;
	endsequence

	hold_raise_a : assert property (hold_done |=> TEST_ALARM_O)
		else $error("test alarm not raised after hold");
	test_cause_a : assert property ($rose(TEST_ALARM_O) |-> $past(KEY_A_I && KEY_B_I, 2))
		else $error("test alarm without key hold");
	esc_clear_a : assert property (TEST_ALARM_O && KEY_ESC_I && !hold_done |=> !TEST_ALARM_O)
		else $error("escape did not clear test alarm");
	fault_latch_a : assert property (ENABLE_FAULT_O && ALARM_RESET_I |=> ENABLE_FAULT_O [*2])
		else $error("enable fault cleared by reset input");
	ind_show_a : assert property (next_minor && !next_disp |=> MINOR_IND_O)
		else $error("indication missing");
	lamp_flip_a : assert property (blink_tick && MINOR_ALARM_O && next_minor |=> LAMP_O != $past(LAMP_O))
		else $error("lamp did not toggle");
	term_route_a : assert property (|TERM_O |-> MINOR_ALARM_O && $past(|term_is_minor))
		else $error("terminal driven without function code");
	class_or_a : assert property (MINOR_ALARM_O == $past(|(COND_I & class_mask)))
		else $error("minor state not OR of selected conditions");
	hist_latest_a : assert property (push |=> hist_latest == $past(push_code))
		else $error("latest factor not recorded");
	disp_keep_a : assert property (disp_normal |-> MINOR_ALARM_O && !MINOR_IND_O)
		else $error("normal display state inconsistent");
	auto_clear_a : assert property (s_clear |-> !MINOR_ALARM_O && !MINOR_IND_O && !LAMP_O && TERM_O == '0)
		else $error("minor alarm outputs not cleared");
	lamp_idle_a : assert property (!MINOR_ALARM_O |-> !LAMP_O)
		else $error("lamp on without minor alarm");
	minor_drop_a : assert property (!next_minor |=> !MINOR_ALARM_O && TERM_O == '0)
		else $error("minor output kept without factors");
	term_code_a : assert property (TERM_O == ({mla_pkg::TERM_N{MINOR_ALARM_O}} & $past(term_is_minor)))
		else $error("terminal routing wrong");
	fault_hold_a : assert property (ENABLE_FAULT_O |=> ENABLE_FAULT_O)
		else $error("enable fault dropped");

	// =========================================================
	// bus handshake
	sequence s_bus_take;
		CYC_I && STB_I && !pend && !ACK_O ##1 pend;
	endsequence

	bus_ack_a : assert property (s_bus_take |=> ACK_O && !pend)
		else $error("bus request not acknowledged");
	ack_once_a : assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
endmodule : mla_annunciator
`default_nettype wire

// [mla_keypad.sv]
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// keypad operator model
module mla_keypad (
	input  wire logic clk_i,      // system clock
	output var  logic key_a_o,    // first key of pair
	output var  logic key_b_o,    // second key of pair
	output var  logic key_esc_o,  // escape key
	output var  logic key_disp_o  // display key
);
	initial begin
		key_a_o = 1'b0;
		key_b_o = 1'b0;
		key_esc_o = 1'b0;
		key_disp_o = 1'b0;
	end
	// holds the key pair for n edges, then lets both go
	task automatic hold_pair(input int n);
		@(posedge clk_i);
		key_a_o <= 1'b1;
		key_b_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		key_a_o <= 1'b0;
		key_b_o <= 1'b0;
	endtask : hold_pair
	// short press of escape, or of display when disp is set
	task automatic tap(input bit disp);
		@(posedge clk_i);
		key_esc_o <= ~disp;
		key_disp_o <= disp;
		repeat (2) @(posedge clk_i);
		key_esc_o <= 1'b0;
		key_disp_o <= 1'b0;
	endtask : tap
endmodule : mla_keypad
`default_nettype wire

// [mla_annunciator_test.sv]
`timescale 1ns/1ps
`default_nettype none
module mla_annunciator_test;
	localparam int HOLD = 20;
	logic        clk, rst, cyc, stb, we, ack, ka, kb, kesc, kdisp, arst, efi;
	logic        test_o, ef_o, ind, lamp, minor, irq;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w, dat_r, cond, rd;
	logic [5:0]  term;
	int          err_total, tests_run, cycles;

	mla_annunciator #(.KEY_HOLD_CYC(HOLD), .BLINK_CYC(4), .N_COND(32)) dut (
		.SYS_CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
		.SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .COND_I(cond), .KEY_A_I(ka),
		.KEY_B_I(kb), .KEY_ESC_I(kesc), .KEY_DISP_I(kdisp), .ALARM_RESET_I(arst),
		.ENABLE_FAULT_I(efi), .TEST_ALARM_O(test_o), .ENABLE_FAULT_O(ef_o), .MINOR_IND_O(ind),
		.LAMP_O(lamp), .MINOR_ALARM_O(minor), .TERM_O(term), .IRQ_O(irq));
	mla_keypad kp (.clk_i(clk), .key_a_o(ka), .key_b_o(kb), .key_esc_o(kesc), .key_disp_o(kdisp));

	// =========================================================
	// helpers
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one classic cycle; request held until the rising edge at which ack is high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1);
		chk("bus ack latency", 32'd3, 32'(n));
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(what, exp, rd & m);
	endtask : rchk
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task automatic set_cond(input logic [31:0] v);
		@(posedge clk);
		cond <= v;
		settle(2);
	endtask : set_cond
	// lamp must toggle about every four cycles
	task automatic lamp_blinks();
		int t;
		logic l;
		t = 0;
		l = lamp;
		repeat (20) begin
			@(negedge clk);
			t += (lamp !== l);
			l = lamp;
		end
		chk("lamp blinking", 32'h1, {31'h0, t >= 4 && t <= 6});
	endtask : lamp_blinks

	// =========================================================
	// clock, reset, timeout
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			complete_run();
		end
	end

	// =========================================================
	// scenarios
	initial begin
		{rst, cyc, stb, we, arst, efi} = 6'h20;
		adr = 8'h00;
		sel = 4'hf;
		dat_w = 32'h0;
		cond = 32'h0;
		err_total = 0;
		tests_run = 0;
		cycles = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		settle(1);
		chk("outputs after reset", 32'h0, {test_o, ef_o, ind, lamp, minor, term, irq});
		rchk("class0 reset", mla_pkg::ADR_CLASS0, 32'hffffffff, mla_pkg::CLASS_RST);
		rchk("term0 reset", mla_pkg::ADR_TERM0, 32'hffffffff, mla_pkg::TERM_RST);
		rchk("mask reset", mla_pkg::ADR_IRQ_MASK, 32'hf, {28'h0, mla_pkg::MASK_RST});
		rchk("hist reset", mla_pkg::ADR_HIST0, 32'hffffffff, 32'h0);
		rchk("unmapped read", 8'h40, 32'hffffffff, 32'h0);
		wb(1'b1, mla_pkg::ADR_CLASS0, 32'h0000_0008);
		wb(1'b1, mla_pkg::ADR_TERM0, 32'h0000_6200);
		wb(1'b1, mla_pkg::ADR_TERM1, 32'h0000_0061);
		wb(1'b1, mla_pkg::ADR_IRQ_MASK, 32'h1);
		rchk("term0 readback", mla_pkg::ADR_TERM0, 32'hffffffff, 32'h0000_6200);
		set_cond(32'h20);
		chk("heavy not minor", 32'h0, {ind, minor, term});
		set_cond(32'h28);
		chk("minor on", 32'h3, {ind, minor});
		chk("terminals", 32'h02, term);
		chk("irq on", 32'h1, irq);
		rchk("latest factor", mla_pkg::ADR_HIST0, 32'hff, 32'h4);
		lamp_blinks();
		wb(1'b1, mla_pkg::ADR_STATUS, 32'h0);
		rchk("status read only", mla_pkg::ADR_STATUS, 32'h1, 32'h1);
		wb(1'b1, mla_pkg::ADR_IRQ_STAT, 32'h1);
		settle(1);
		chk("irq cleared", 32'h0, irq);
		kp.tap(1'b1);
		settle(1);
		chk("display normal", 32'h1, {ind, minor});
		lamp_blinks();
		set_cond(32'h8);
		wb(1'b1, mla_pkg::ADR_CLASS0, 32'hffff_ffff);
		set_cond(32'h88);
		set_cond(32'h8a);
		set_cond(32'h48a);
		rchk("hist latest", mla_pkg::ADR_HIST0, 32'hff, 32'd11);
		rchk("hist last", 8'h24, 32'hff, 32'd2);
		rchk("hist 2nd last", 8'h28, 32'hff, 32'd8);
		rchk("hist 3rd last", mla_pkg::ADR_HIST_END, 32'hff, 32'd4);
		set_cond(32'h400);
		chk("minor remains", 32'h1, minor);
		lamp_blinks();
		set_cond(32'h0);
		chk("minor gone", 32'h0, {ind, lamp, minor, term});
		rchk("minor off event", mla_pkg::ADR_IRQ_STAT, 32'h2, 32'h2);
		kp.hold_pair(HOLD - 5);
		settle(3);
		chk("short hold", 32'h0, test_o);
		kp.hold_pair(HOLD + 5);
		settle(3);
		chk("long hold", 32'h1, test_o);
		rchk("test raised event", mla_pkg::ADR_IRQ_STAT, 32'h4, 32'h4);
		kp.tap(1'b0);
		settle(1);
		chk("escape clears", 32'h0, test_o);
		@(posedge clk);
		efi <= 1'b1;
		@(posedge clk);
		efi <= 1'b0;
		settle(2);
		chk("fault latched", 32'h1, ef_o);
		rchk("fault event", mla_pkg::ADR_IRQ_STAT, 32'h8, 32'h8);
		@(posedge clk);
		arst <= 1'b1;
		settle(3);
		chk("fault kept", 32'h1, ef_o);
		@(posedge clk);
		arst <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle(1);
		chk("fault power-on clear", 32'h0, ef_o);
		complete_run();
	end
endmodule : mla_annunciator_test
`default_nettype wire
